// *** ast_uart.sv ***
// Full-duplex asynchronous serial transceiver with AXI4-Lite registers.
// Assumes the serial input is asynchronous; port logic applies pin_ctl.
`timescale 1ns/10ps
module ast_uart
  import ast_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial lines
  input  wire logic        rxd_in,
  output ast_pins_t        pin_ctl,
  // Interrupt requests and vector acknowledge
  output ast_irq_t         irq_req,
  input  wire logic        tx_done_vec_ack
);

  // Index of a word address
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    return a[9:2];
  endfunction

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [7:0]  control_ff;      // Enables and ninth bits
  logic [7:0]  divider_ff;      // Baud divider
  logic [7:0]  tx_hold_ff;      // Transmit holding register
  logic        tx_hold8_ff;     // Ninth bit captured with hold
  logic        tx_pend_ff;      // Hold has a character waiting
  logic [10:0] tx_shift_ff;     // Transmit shifter
  logic [3:0]  tx_left_ff;      // Bits still to shift out
  logic        tx_busy_ff;      // Frame on the line
  logic        tx_line_ff;      // Serial output level
  logic        tx_stop_ff;      // Stop bit out, nothing queued
  logic [7:0]  rx_buf_ff;       // Receive holding register
  logic        rx8_ff;          // Received ninth bit
  logic        rx_done_ff;      // Receive done flag
  logic        tx_done_ff;      // Transmit done flag
  logic        empty_ff;        // Buffer empty flag
  logic        frame_ff;        // Framing error flag
  logic        over_ff;         // Visible overrun
  logic        over_pend_ff;    // Overrun waiting for read
  logic        rxd_s1_ff;       // Synchroniser first stage
  logic        rxd_s2_ff;       // Synchroniser second stage
  logic [7:0]  div_cnt_ff;      // Divider count
  logic [3:0]  tick_cnt_ff;     // Sixteenths for the transmitter
  logic        ovs_tick;        // One pulse per 1/16 bit
  logic        baud_tick;       // One pulse per bit
  ast_rx_state_t rx_state_ff;   // Receiver state
  logic [3:0]  rx_ovs_ff;       // Sample index in bit
  logic [2:0]  rx_smp_ff;       // Samples 8..10
  logic [3:0]  rx_bit_ff;       // Data bits received
  logic [8:0]  rx_shift_ff;     // Receive shifter
  logic        aw_got_ff;       // Write address held
  logic        w_got_ff;        // Write data held
  logic [31:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        wr_fire;         // Write executes this cycle
  logic        rd_fire;         // Read executes this cycle
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        data_wr;         // Write to data address
  logic        data_rd;         // Read of data address
  logic        tx_load;         // Hold moves into shifter
  logic        stop_out;        // Last bit finished
  logic        rx_end;          // Frame end strobe
  logic        rx_stop_ok;
  logic [7:0]  status_rd;

  // Bus write taken once both halves are in hand
  assign wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_idx  = word_idx(aw_addr_ff);
  assign rd_idx  = word_idx(s_axi_araddr);
  assign data_wr = wr_fire & (wr_idx == IDX_DATA) & w_strb_ff[0];
  assign data_rd = rd_fire & (rd_idx == IDX_DATA);
  assign status_rd = {rx_done_ff, tx_done_ff, empty_ff, frame_ff,
                      over_ff, 3'h0};

  // Address and data channels accepted independently
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 32'h0;
      w_data_ff     <= 32'h0;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_got_ff & ~s_axi_awready & ~wr_fire;
      s_axi_wready  <= ~w_got_ff & ~s_axi_wready & ~wr_fire;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped index
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_idx == IDX_CONTROL || wr_idx == IDX_STATUS ||
          wr_idx == IDX_DATA || wr_idx == IDX_DIVIDER ||
          wr_idx == IDX_IRQ_ACK) begin
        s_axi_bresp <= RESP_OK;
      end else begin
        s_axi_bresp <= RESP_ERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle answer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        if (rd_idx == IDX_CONTROL) begin
          s_axi_rdata <= {24'h0, control_ff[7:2], rx8_ff, 1'b0};
        end else if (rd_idx == IDX_STATUS) begin
          s_axi_rdata <= {24'h0, status_rd};
        end else if (rd_idx == IDX_DATA) begin
          s_axi_rdata <= {24'h0, rx_buf_ff};
        end else if (rd_idx == IDX_DIVIDER) begin
          s_axi_rdata <= {24'h0, divider_ff};
        end else if (rd_idx == IDX_IRQ_ACK) begin
          s_axi_rdata <= 32'h0;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_ERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control and divider registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      control_ff <= CONTROL_RST;
      divider_ff <= DIVIDER_RST;
    end else if (wr_fire & w_strb_ff[0]) begin
      if (wr_idx == IDX_CONTROL) begin
        control_ff <= w_data_ff[7:0];
      end else if (wr_idx == IDX_DIVIDER) begin
        divider_ff <= w_data_ff[7:0];
      end
    end
  end

  // Divider makes 16x ticks; transmitter uses every 16th
  assign ovs_tick  = (div_cnt_ff == divider_ff);
  assign baud_tick = ovs_tick & (tick_cnt_ff == OVS_LAST);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_ff  <= 8'h0;
      tick_cnt_ff <= 4'h0;
    end else if (ovs_tick) begin
      div_cnt_ff  <= 8'h0;
      tick_cnt_ff <= tick_cnt_ff + 4'h1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h1;
    end
  end

  // Transmit hold: written any time, drained by loads
  assign stop_out = tx_busy_ff & baud_tick & (tx_left_ff == 4'h0);
  // Enable gates only new starts, so queued data still drains
  assign tx_load  = tx_pend_ff & ((~tx_busy_ff & control_ff[CTL_TRANSMITTER_ENABLE])
                    | stop_out);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold_ff  <= 8'h0;
      tx_hold8_ff <= 1'b0;
      tx_pend_ff  <= 1'b0;
    end else if (data_wr) begin
      tx_hold_ff  <= w_data_ff[7:0];
      tx_hold8_ff <= control_ff[CTL_TX8];
      tx_pend_ff  <= 1'b1;
    end else if (tx_load) begin
      tx_pend_ff <= 1'b0;
    end
  end

  // Shifter: start low at bit 0, stop high at top
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_shift_ff <= 11'h7ff;
      tx_left_ff  <= 4'h0;
      tx_busy_ff  <= 1'b0;
      tx_line_ff  <= 1'b1;
    end else if (tx_load) begin
      tx_busy_ff <= 1'b1;
      if (control_ff[CTL_NINE]) begin
        tx_shift_ff <= {1'b1, tx_hold8_ff, tx_hold_ff, 1'b0};
        tx_left_ff  <= 4'ha;
      end else begin
        tx_shift_ff <= {2'b11, tx_hold_ff, 1'b0};
        tx_left_ff  <= 4'h9;
      end
    end else if (tx_busy_ff & baud_tick) begin
      if (tx_left_ff == 4'h0) begin
        tx_busy_ff <= 1'b0;
        tx_line_ff <= 1'b1;
      end else begin
        tx_line_ff  <= tx_shift_ff[0];
        tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
        tx_left_ff  <= tx_left_ff - 4'h1;
      end
    end
  end

  // Empty flag: load sets it and wins over the write clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      empty_ff <= STATUS_RST[ST_EMPTY];
    end else if (tx_load) begin
      empty_ff <= 1'b1;
    end else if (data_wr) begin
      empty_ff <= 1'b0;
    end
  end

  // Stop bit timer: armed by an unfollowed stop, ends one bit later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_stop_ff <= 1'b0;
    end else if (stop_out) begin
      tx_stop_ff <= ~tx_pend_ff;
    end else if (baud_tick | tx_load) begin
      tx_stop_ff <= 1'b0;
    end
  end

  // Transmit done: set beats the clears; waits a full stop bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_done_ff <= 1'b0;
    end else if (tx_stop_ff & baud_tick & ~tx_pend_ff & ~data_wr) begin
      tx_done_ff <= 1'b1;
    end else if (tx_done_vec_ack) begin
      tx_done_ff <= 1'b0;
    end else if (wr_fire & w_strb_ff[0] & (wr_idx == IDX_STATUS) &
                 w_data_ff[ST_TXDONE]) begin
      tx_done_ff <= 1'b0;
    end
  end

  // Two-flop synchroniser on the serial input
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= rxd_in;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  // Receiver: 16 samples a bit, vote on samples 8..10
  assign rx_stop_ok = maj3(rx_smp_ff);
  assign rx_end = ovs_tick & (rx_state_ff == RX_STOP) &
                  (rx_ovs_ff == OVS_LAST);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_ff <= RX_IDLE;
      rx_ovs_ff   <= 4'h0;
      rx_smp_ff   <= 3'h0;
      rx_bit_ff   <= 4'h0;
      rx_shift_ff <= 9'h0;
    end else if (!control_ff[CTL_RECEIVER_ENABLE]) begin
      rx_state_ff <= RX_IDLE;
    end else if (ovs_tick) begin
      rx_ovs_ff <= rx_ovs_ff + 4'h1;
      if (rx_ovs_ff == SMP_A || rx_ovs_ff == SMP_B ||
          rx_ovs_ff == SMP_C) begin
        rx_smp_ff <= {rx_smp_ff[1:0], rxd_s2_ff};
      end
      case (rx_state_ff)
        RX_IDLE: begin
          // First low sample is sample 1, index 0
          rx_ovs_ff <= 4'h1;
          if (!rxd_s2_ff) begin
            rx_state_ff <= RX_START;
          end
        end
        RX_START: begin
          if (rx_ovs_ff == OVS_LAST) begin
            rx_bit_ff <= 4'h0;
            if (maj3(rx_smp_ff)) begin
              rx_state_ff <= RX_IDLE;
            end else begin
              rx_state_ff <= RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_ovs_ff == OVS_LAST) begin
            rx_shift_ff <= {maj3(rx_smp_ff), rx_shift_ff[8:1]};
            rx_bit_ff   <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == (control_ff[CTL_NINE] ? 4'h8 : 4'h7)) begin
              rx_state_ff <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_ovs_ff == OVS_LAST) begin
            rx_state_ff <= RX_IDLE;
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // Frame end: move character unless buffer still unread
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_buf_ff    <= 8'h0;
      rx8_ff       <= 1'b0;
      rx_done_ff   <= 1'b0;
      frame_ff     <= 1'b0;
      over_ff      <= 1'b0;
      over_pend_ff <= 1'b0;
    end else begin
      if (rx_end & (~rx_done_ff | data_rd)) begin
        // Transfer; a same-cycle read frees the buffer
        rx_done_ff   <= 1'b1;
        frame_ff     <= ~rx_stop_ok;
        over_pend_ff <= 1'b0;
        over_ff      <= 1'b0;
        if (control_ff[CTL_NINE]) begin
          rx_buf_ff <= rx_shift_ff[7:0];
          rx8_ff    <= rx_shift_ff[8];
        end else begin
          rx_buf_ff <= rx_shift_ff[8:1];
        end
      end else if (rx_end) begin
        over_pend_ff <= 1'b1;
        frame_ff     <= ~rx_stop_ok;
      end else if (data_rd) begin
        rx_done_ff <= 1'b0;
        over_ff    <= over_pend_ff;
      end
    end
  end

  // Pins and interrupt requests, all registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // Line idles high through reset, pin not yet owned
      pin_ctl <= '{tx_out: 1'b1, tx_oe: 1'b0, rx_oe: 1'b0};
      irq_req <= '0;
    end else begin
      pin_ctl.tx_out <= tx_line_ff;
      // Keep driving while queued data drains
      pin_ctl.tx_oe  <= control_ff[CTL_TRANSMITTER_ENABLE] | tx_busy_ff | tx_pend_ff
                        & ~empty_ff;
      pin_ctl.rx_oe  <= 1'b0;
      irq_req.rx_done   <= rx_done_ff & control_ff[CTL_RXIE];
      irq_req.tx_done   <= tx_done_ff & control_ff[CTL_TXIE];
      irq_req.buf_empty <= empty_ff & control_ff[CTL_BEIE];
    end
  end

endmodule

// *** ast_pkg.sv ***
// Package for the asynchronous serial transceiver.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package ast_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h0a;
  localparam logic [7:0] IDX_STATUS  = 8'h0b;
  localparam logic [7:0] IDX_DATA    = 8'h0c;
  localparam logic [7:0] IDX_DIVIDER = 8'h09;
  localparam logic [7:0] IDX_IRQ_ACK = 8'h0d;
  // Control field positions
  localparam int CTL_RXIE = 7;
  localparam int CTL_TXIE = 6;
  localparam int CTL_BEIE = 5;
  localparam int CTL_RECEIVER_ENABLE = 4;
  localparam int CTL_TRANSMITTER_ENABLE = 3;
  localparam int CTL_NINE = 2;
  localparam int CTL_RX8  = 1;
  localparam int CTL_TX8  = 0;
  // Status field positions
  localparam int ST_RXDONE = 7;
  localparam int ST_TXDONE = 6;
  localparam int ST_EMPTY  = 5;
  localparam int ST_FRAME  = 4;
  localparam int ST_OVER   = 3;
  // Reset values
  localparam logic [7:0] STATUS_RST  = 8'h20;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DIVIDER_RST = 8'h00;
  // Oversampling, majority sample points and bus responses
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_B    = 4'h8;
  localparam logic [3:0] SMP_C    = 4'h9;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ast_rx_state_t;
  // Pin triple for the two serial lines
  typedef struct packed {
    logic tx_out;
    logic tx_oe;
    logic rx_oe;
  } ast_pins_t;
  // Interrupt request group
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic buf_empty;
  } ast_irq_t;
endpackage

// *** ast_uart_assertions.sv ***
// Checker for the serial transceiver's bus and line behaviour.
// Assumes it is bound to ast_uart and sees only its ports.
`timescale 1ns/10ps
module ast_uart_assertions
  import ast_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Serial pins and requests
  input wire ast_pins_t   pin_ctl,
  input wire ast_irq_t    irq_req
);
  logic [15:0] low_ff;  // Cycles the output has been low
  logic [4:0]  hi_ff;   // Cycles high, saturates at 16
  logic [31:0] ar_ff;   // Address of the read under way
  logic        mapped;  // Read address is a known register
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Run lengths of the serial output
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_ff <= '0;
      hi_ff  <= '0;
    end else if (pin_ctl.tx_out) begin
      low_ff <= '0;
      hi_ff  <= (hi_ff == 5'h10) ? hi_ff : hi_ff + 5'h01;
    end else begin
      low_ff <= low_ff + 16'h0001;
      hi_ff  <= '0;
    end
  end
  // Latch the read address at its handshake
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ar_ff <= '0;
    else if (s_axi_arvalid && s_axi_arready) ar_ff <= s_axi_araddr;
  end
  assign mapped = (ar_ff[31:2] >= 30'h9) && (ar_ff[31:2] <= 30'hd);
  a_rx_pin_input: assert property (pin_ctl.rx_oe == 1'b0)
    else $error("receive pin driven");
  a_low_owned: assert property (!pin_ctl.tx_out |-> pin_ctl.tx_oe)
    else $error("low output while pin not owned");
  // Any low run is whole bit times of sixteen samples
  a_bit_length: assert property ($rose(pin_ctl.tx_out)
    |-> low_ff[3:0] == 4'h0) else $error("bit time not a multiple of 16");
  a_done_stop: assert property ($rose(irq_req.tx_done)
    |-> pin_ctl.tx_out && hi_ff == 5'h10) else $error("done before stop");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_resp_map: assert property ($rose(s_axi_rvalid)
    |-> s_axi_rresp == (mapped ? RESP_OK : RESP_ERR))
    else $error("wrong read response");
  c_rx_irq: cover property ($rose(irq_req.rx_done));
  c_tx_irq: cover property ($rose(irq_req.tx_done));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_ERR);
endmodule
bind ast_uart ast_uart_assertions chk_u (.sys_clk, .nrst, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pin_ctl, .irq_req);

// *** ast_remote.sv ***
// Remote serial port model facing the transceiver's pins.
// Assumes 16 clocks a bit (divider 0) and a pulled-up line.
`timescale 1ns/10ps
module ast_remote (
  // Clock and line side
  input  wire logic sys_clk,
  input  wire logic tx_line,
  input  wire logic nine,
  output logic      rx_line
);
  logic [8:0] got[$];  // Frames heard, oldest first
  logic [8:0] sh;      // Receive shifter
  initial rx_line = 1'b1;  // Idle high
  // Hear a frame at mid bit; a missing stop drops it
  always begin
    @(negedge tx_line);
    repeat (8) @(posedge sys_clk);
    sh = '0;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (16) @(posedge sys_clk);
      sh[i] = tx_line;
    end
    repeat (16) @(posedge sys_clk);
    if (tx_line) got.push_back(sh);
  end
  // Send one frame, LSB first; stp is the stop level
  task automatic send(input logic [8:0] v, input logic stp);
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (16) @(posedge sys_clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rx_line <= v[i];
      repeat (16) @(posedge sys_clk);
    end
    rx_line <= stp;
    repeat (stp ? 16 : 12) @(posedge sys_clk);
    rx_line <= 1'b1;
    repeat (16) @(posedge sys_clk);
  endtask
  // Short glitch, shorter than the mid-bit samples
  task automatic spike();
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rx_line <= 1'b1;
  endtask
endmodule

// *** async_serial_transceiver_test.sv ***
// Self-checking bench for the serial transceiver.
// Assumes the remote model and the bound checker are compiled.
`timescale 1ns/10ps
module async_serial_transceiver_test
  import ast_pkg::*;
;
  logic        sys_clk, nrst, nine, ack, rxd;  // Clock, reset, misc
  logic [31:0] awaddr, wdata, araddr, rdat;    // Bus payloads
  logic        awvalid, wvalid, bready;        // Write master side
  logic        arvalid, rready;                // Read master side
  logic        awready, wready, bvalid;        // Write slave side
  logic        arready, rvalid;                // Read slave side
  logic [1:0]  bresp, rresp, rres;             // Responses
  logic [31:0] rdata;                          // Read data
  logic [7:0]  v, w;                           // Test characters
  ast_pins_t   pins;                           // Serial pin controls
  ast_irq_t    irq;                            // Interrupt levels
  int          bad_count, cmp_count, cyc;      // Tallies
  ast_uart dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd_in(rxd),
    .pin_ctl(pins), .irq_req(irq), .tx_done_vec_ack(ack));
  // Line idles high when the pin is released
  ast_remote rem_u (.sys_clk(sys_clk), .nine(nine), .rx_line(rxd),
    .tx_line(pins.tx_oe ? pins.tx_out : 1'b1));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic flag(input logic f, input logic e);
    chk({8'h0, f}, {8'h0, e});
  endtask
  // Frame as the remote hears it; ninth bit only in nine-bit mode
  function automatic logic [8:0] frame(input logic [7:0] d, input logic t);
    return {nine & t, d};
  endfunction
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    awaddr  <= {22'h0, i, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge sys_clk);
    araddr  <= {22'h0, i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdat = rdata;
    rres = rresp;
    rready <= 1'b0;
  endtask
  // Read status until a flag shows, bounded
  task automatic poll(input int b);
    rd(IDX_STATUS);
    for (int n = 0; n < 60 && !rdat[b]; n++) rd(IDX_STATUS);
  endtask
  task automatic tx_got(input logic [8:0] e);
    while (rem_u.got.size() == 0) @(posedge sys_clk);
    chk(rem_u.got.pop_front(), e);
  endtask
  task automatic rx_one(input logic [7:0] d, input logic stp);
    rem_u.send({1'b1, d}, stp);
    poll(ST_RXDONE);
  endtask
  initial begin
    {nrst, nine, ack, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, cyc, bad_count, cmp_count} = '0;
    void'($urandom(25));
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(IDX_STATUS);
    chk(rdat[8:0], {1'b0, STATUS_RST});
    rd(8'h20);
    chk({7'h0, rres}, {7'h0, RESP_ERR});
    wr(IDX_DIVIDER, 8'h00);
    // All three interrupt enables on, both directions running
    wr(IDX_CONTROL, 8'hf8);
    repeat (2) @(posedge sys_clk);
    flag(irq.buf_empty, 1'b1);
    flag(pins.tx_oe, 1'b1);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(IDX_DATA, v);
      tx_got(frame(v, 1'b0));
      v = 8'($urandom);
      rx_one(v, 1'b1);
      flag(irq.rx_done, 1'b1);
      rd(IDX_DATA);
      chk(rdat[8:0], {1'b0, v});
      repeat (2) @(posedge sys_clk);
      flag(irq.rx_done, 1'b0);
    end
    repeat (24) @(posedge sys_clk);
    flag(irq.tx_done, 1'b1);
    @(posedge sys_clk) ack <= 1'b1;
    @(posedge sys_clk) ack <= 1'b0;
    rd(IDX_STATUS);
    flag(rdat[ST_TXDONE], 1'b0);
    v = 8'($urandom);
    w = v ^ 8'hff;
    wr(IDX_DATA, v);
    wr(IDX_DATA, w);
    rd(IDX_STATUS);
    flag(rdat[ST_EMPTY], 1'b0);
    tx_got(frame(v, 1'b0));
    tx_got(frame(w, 1'b0));
    repeat (24) @(posedge sys_clk);
    rd(IDX_STATUS);
    flag(rdat[ST_TXDONE], 1'b1);
    flag(rdat[ST_EMPTY], 1'b1);
    wr(IDX_STATUS, 8'h40);
    rd(IDX_STATUS);
    flag(rdat[ST_TXDONE], 1'b0);
    // Bad stop, then a good one
    rx_one(v, 1'b0);
    flag(rdat[ST_FRAME], 1'b1);
    rd(IDX_DATA);
    chk(rdat[8:0], {1'b0, v});
    rx_one(w, 1'b1);
    flag(rdat[ST_FRAME], 1'b0);
    rd(IDX_DATA);
    // Second frame lost while the first is unread
    rx_one(v, 1'b1);
    rx_one(w, 1'b1);
    rd(IDX_DATA);
    chk(rdat[8:0], {1'b0, v});
    rd(IDX_STATUS);
    flag(rdat[ST_OVER], 1'b1);
    rx_one(w, 1'b1);
    flag(rdat[ST_OVER], 1'b0);
    rd(IDX_DATA);
    rem_u.spike();
    repeat (300) @(posedge sys_clk);
    rd(IDX_STATUS);
    flag(rdat[ST_RXDONE], 1'b0);
    // Disable while sending: the character still goes out
    wr(IDX_DATA, w);
    wr(IDX_CONTROL, 8'h10);
    tx_got(frame(w, 1'b0));
    repeat (40) @(posedge sys_clk);
    flag(pins.tx_oe, 1'b0);
    nine <= 1'b1;
    wr(IDX_CONTROL, 8'hdd);
    wr(IDX_DATA, v);
    tx_got(frame(v, 1'b1));
    rx_one(w, 1'b1);
    rd(IDX_CONTROL);
    flag(rdat[CTL_RX8], 1'b1);
    rd(IDX_DATA);
    chk(rdat[8:0], {1'b0, w});
    end_sim();
  end
endmodule
